// ==== verilog/dac_link_pkg.sv ====
// Shared constants for the dual DAC serial loader link
`default_nettype none
package dac_link_pkg;

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int         WORD_BITS = 16;
   localparam int         DATA_BITS = 12;
   localparam int         CNT_W     = 5;
   localparam logic [4:0] WORD_LEN  = 5'h10;
   localparam logic [4:0] BYTE_LEN  = 5'h08;
   localparam logic [4:0] CNT_ZERO  = 5'h00;
   localparam logic [4:0] CNT_ONE   = 5'h01;
   localparam int         SEL_HI_POS = 15;
   localparam int         SPEED_POS  = 14;
   localparam int         PD_POS     = 13;
   localparam int         SEL_LO_POS = 12;
   localparam int         MSB_POS    = 15;

   // Register-select codes {reg_select_hi, reg_select_lo}
   localparam logic [1:0] SEL_B_AND_BUF = 2'h0;
   localparam logic [1:0] SEL_BUF_ONLY  = 2'h1;
   localparam logic [1:0] SEL_A_UPD_B   = 2'h2;
   localparam logic [1:0] SEL_RESERVED  = 2'h3;

   localparam logic [11:0] CODE_ZERO = 12'h000;

   // ----------------------------------------------------------------
   // Controller command port
   // ----------------------------------------------------------------
   localparam int         ADDR_W       = 2;
   localparam logic [1:0] ADDR_WORD    = 2'h0;
   localparam logic [1:0] ADDR_CFG     = 2'h1;
   localparam logic [1:0] ADDR_STATUS  = 2'h2;
   localparam int         CFG_BYTE_POS = 0;
   localparam int         STAT_BUSY_POS = 0;
   localparam int         STAT_PEND_POS = 1;
   localparam int         STAT_CNT_LSB  = 8;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int REF_PERIOD_NS     = 100;
   localparam int SCLK_MIN_HALF_NS  = 25;
   localparam int SCLK_HALF_MIN_CYC =
      (SCLK_MIN_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int BYTE_GAP_NS       = 1000;
   localparam int BYTE_GAP_CYC      =
      (BYTE_GAP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

endpackage
`default_nettype wire

// ==== verilog/dac_link_if.sv ====
// Three-wire serial link between controller and DAC loader
`default_nettype none
interface dac_link_if;
   logic cs_n;
   logic sclk;
   logic din;

   modport host
   (
      output cs_n,
      output sclk,
      output din
   );

   modport device
   (
      input cs_n,
      input sclk,
      input din
   );
endinterface
`default_nettype wire

// ==== verilog/dac_loader_device.sv ====
// Serial shift, decode and latch logic of the dual DAC, on the link clock
//
// The register offsets and strobed register access are this design's own decisions.
`default_nettype none

module dac_loader_device
   import dac_link_pkg::*;
(
   // Serial link, its clock clocks this module
   dac_link_if.device         link,
   // Power-on reset from another domain, synchronised here
   input  wire logic          rst,
   // Converter codes
   output logic [DATA_BITS-1:0] dac_a_code,
   output logic [DATA_BITS-1:0] dac_b_code,
   output logic [DATA_BITS-1:0] hold_code,
   // Control state
   output logic               speed_select,
   output logic               power_down_flag,
   // Load events and last word
   output logic               word_loaded,
   output logic               partial_loaded,
   output logic               reserved_seen,
   output logic [WORD_BITS-1:0] last_word
);

   // ----------------------------------------------------------------
   // Falling-edge receive state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WORD_BITS-1:0] shift;
      logic [CNT_W-1:0]     cnt;
      // Power-on reset chain and the level the module acts on
      logic                 rst_m1;
      logic                 rst_m2;
      logic                 rst_m3;
      logic                 rst_q;
   } rx_s;

   rx_s rx_ff;
   rx_s nxt_rx;

   always_comb
   begin
      nxt_rx = rx_ff;
      if (rx_ff.rst_q)
      begin
         // Also clears the chain; it is refilled at the end
         nxt_rx = '0;
      end
      else if (link.cs_n)
      begin
         // Cleared here, one half period after the rising edge that
         // may still need the partial contents
         nxt_rx.cnt   = CNT_ZERO;
         nxt_rx.shift = '0;
      end
      else if (rx_ff.cnt != WORD_LEN)
      begin
         // Bits past the sixteenth are ignored until select rises
         nxt_rx.shift = {rx_ff.shift[WORD_BITS-2:0], link.din};
         nxt_rx.cnt   = rx_ff.cnt + CNT_ONE;
      end

      // Power-on reset is not timed to the link clock: three stages,
      // and a level counts only once the second and third agree,
      // so a short glitch on the pin cannot half-reset the latches
      nxt_rx.rst_m1 = rst;
      nxt_rx.rst_m2 = rx_ff.rst_m1;
      nxt_rx.rst_m3 = rx_ff.rst_m2;
      nxt_rx.rst_q  = rx_ff.rst_q;
      if (rx_ff.rst_m2 == rx_ff.rst_m3)
      begin
         nxt_rx.rst_q = rx_ff.rst_m3;
      end
   end

   always_ff @(negedge link.sclk)
   begin
      rx_ff <= nxt_rx;
   end

   // ----------------------------------------------------------------
   // Rising-edge latch state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DATA_BITS-1:0] dac_a;
      logic [DATA_BITS-1:0] dac_b;
      logic [DATA_BITS-1:0] hold;
      logic                 speed;
      logic                 pd;
      logic                 done;
      logic                 loaded;
      logic                 partial;
      logic                 rsvd;
      logic [WORD_BITS-1:0] word;
   } lat_s;

   lat_s lat_ff;
   lat_s nxt_lat;

   logic                 full_word;
   logic                 early_end;
   logic                 load;
   logic [WORD_BITS-1:0] word;
   logic [1:0]           sel;
   logic [DATA_BITS-1:0] data;

   always_comb
   begin
      word      = rx_ff.shift;
      sel       = {word[SEL_HI_POS], word[SEL_LO_POS]};
      data      = word[DATA_BITS-1:0];
      full_word = (rx_ff.cnt == WORD_LEN);
      early_end = link.cs_n && (rx_ff.cnt != CNT_ZERO)
                  && (rx_ff.cnt != WORD_LEN);
      load      = !lat_ff.done && (full_word || early_end);
   end

   always_comb
   begin
      nxt_lat         = lat_ff;
      nxt_lat.loaded  = 1'b0;
      nxt_lat.partial = 1'b0;
      nxt_lat.rsvd    = 1'b0;
      if (rx_ff.rst_q)
      begin
         // Synchronised level from the falling-edge side
         // All latches and both control bits come up zero
         nxt_lat = '0;
      end
      else
      begin
         if (rx_ff.cnt == CNT_ZERO)
         begin
            nxt_lat.done = 1'b0;
         end
         if (load)
         begin
            nxt_lat.done    = 1'b1;
            nxt_lat.loaded  = 1'b1;
            nxt_lat.partial = early_end;
            nxt_lat.word    = word;
            nxt_lat.speed   = word[SPEED_POS];
            // Power-down wins in the analogue section whatever else
            // the word carries, so the flag is taken unconditionally
            nxt_lat.pd      = word[PD_POS];
            unique case (sel)
               SEL_B_AND_BUF:
               begin
                  nxt_lat.dac_b = data;
                  nxt_lat.hold  = data;
               end
               SEL_BUF_ONLY:
               begin
                  nxt_lat.hold = data;
               end
               SEL_A_UPD_B:
               begin
                  // Both outputs move on the same edge
                  nxt_lat.dac_a = data;
                  nxt_lat.dac_b = lat_ff.hold;
               end
               SEL_RESERVED:
               begin
                  nxt_lat.rsvd = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge link.sclk)
   begin
      lat_ff <= nxt_lat;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign dac_a_code      = lat_ff.dac_a;
   assign dac_b_code      = lat_ff.dac_b;
   assign hold_code       = lat_ff.hold;
   assign speed_select    = lat_ff.speed;
   assign power_down_flag = lat_ff.pd;
   assign word_loaded     = lat_ff.loaded;
   assign partial_loaded  = lat_ff.partial;
   assign reserved_seen   = lat_ff.rsvd;
   assign last_word       = lat_ff.word;

endmodule
`default_nettype wire

// ==== verilog/dac_loader_host.sv ====
// Serial controller that sends 16-bit words to the DAC loader
`default_nettype none
module dac_loader_host
   import dac_link_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_MIN_CYC
)
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Command port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [15:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [15:0]       rdata,
   // Serial link
   dac_link_if.host               link
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_GAP   = 3'b100
   } host_st_e;

   typedef struct packed {
      host_st_e             st;
      logic [7:0]           div;
      logic                 sclk;
      logic                 cs_n;
      logic                 din;
      logic [WORD_BITS-1:0] word;
      logic [CNT_W-1:0]     bits;
      logic [7:0]           gap;
      logic                 pend;
      logic                 byte_mode;
      logic [7:0]           sent;
      logic [15:0]          rdata;
   } host_s;

   host_s s_ff;
   host_s nxt_s;

   logic tick;
   logic rise;
   logic busy;

   always_comb
   begin
      nxt_s = s_ff;
      tick  = (s_ff.div == 8'(HALF_CYC - 1));
      rise  = (s_ff.st != ST_GAP) && tick && !s_ff.sclk;
      busy  = s_ff.pend || (s_ff.st != ST_IDLE);

      // Divider; half period never below 25 ns at the 100 ns clock
      if (s_ff.st != ST_GAP)
      begin
         if (tick)
         begin
            nxt_s.div  = 8'h00;
            nxt_s.sclk = !s_ff.sclk;
         end
         else
         begin
            nxt_s.div = s_ff.div + 8'h01;
         end
      end

      nxt_s.rdata = 16'h0000;
      if (rd)
      begin
         unique case (addr)
            ADDR_WORD:   nxt_s.rdata = s_ff.word;
            ADDR_CFG:    nxt_s.rdata[CFG_BYTE_POS] = s_ff.byte_mode;
            ADDR_STATUS:
            begin
               nxt_s.rdata[STAT_BUSY_POS] = busy;
               nxt_s.rdata[STAT_PEND_POS] = s_ff.pend;
               nxt_s.rdata[STAT_CNT_LSB +: 8] = s_ff.sent;
            end
            default:     nxt_s.rdata = 16'h0000;
         endcase
      end

      // A word written while busy is dropped
      if (wr && (addr == ADDR_WORD) && !busy)
      begin
         nxt_s.word = wdata;
         nxt_s.pend = 1'b1;
      end
      if (wr && (addr == ADDR_CFG))
      begin
         nxt_s.byte_mode = wdata[CFG_BYTE_POS];
      end

      unique case (s_ff.st)
         ST_IDLE:
         begin
            if (s_ff.pend && rise)
            begin
               // Select falls half a period before the first sample
               nxt_s.cs_n = 1'b0;
               nxt_s.din  = s_ff.word[MSB_POS];
               nxt_s.word = {s_ff.word[WORD_BITS-2:0], 1'b0};
               nxt_s.bits = CNT_ONE;
               nxt_s.pend = 1'b0;
               nxt_s.st   = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (rise)
            begin
               if (s_ff.bits == WORD_LEN)
               begin
                  // Rising edge after the 16th fall loads the latches
                  nxt_s.cs_n = 1'b1;
                  nxt_s.din  = 1'b0;
                  nxt_s.sent = s_ff.sent + 8'h01;
                  nxt_s.st   = ST_IDLE;
               end
               else
               begin
                  nxt_s.din  = s_ff.word[MSB_POS];
                  nxt_s.word = {s_ff.word[WORD_BITS-2:0], 1'b0};
                  nxt_s.bits = s_ff.bits + CNT_ONE;
                  if (s_ff.byte_mode && (s_ff.bits == BYTE_LEN))
                  begin
                     // Clock parks high between the two byte writes
                     nxt_s.gap = 8'h00;
                     nxt_s.st  = ST_GAP;
                  end
               end
            end
         end
         ST_GAP:
         begin
            nxt_s.gap = s_ff.gap + 8'h01;
            if (s_ff.gap == 8'(BYTE_GAP_CYC - 1))
            begin
               nxt_s.st = ST_SHIFT;
            end
         end
         default: nxt_s.st = ST_IDLE;
      endcase

      if (rst)
      begin
         nxt_s      = '0;
         nxt_s.st   = ST_IDLE;
         nxt_s.sclk = 1'b1;
         nxt_s.cs_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      s_ff <= nxt_s;
   end

   assign rdata     = s_ff.rdata;
   assign link.cs_n = s_ff.cs_n;
   assign link.sclk = s_ff.sclk;
   assign link.din  = s_ff.din;

endmodule
`default_nettype wire

// ==== tb/dac_link_monitor.sv ====
// Concurrent checks on the serial link and the latches of the DAC loader
`default_nettype none
module dac_link_monitor
   import dac_link_pkg::*;
(
   // Link and power-on reset
   input wire logic                 cs_n,
   input wire logic                 sclk,
   input wire logic                 din,
   input wire logic                 rst,
   // Device outputs
   input wire logic [DATA_BITS-1:0] dac_a_code,
   input wire logic [DATA_BITS-1:0] dac_b_code,
   input wire logic [DATA_BITS-1:0] hold_code,
   input wire logic                 speed_select,
   input wire logic                 power_down_flag,
   input wire logic                 word_loaded,
   input wire logic                 partial_loaded,
   input wire logic                 reserved_seen,
   input wire logic [WORD_BITS-1:0] last_word
);
   // ----------------------------------------------------------------
   // Reference shift model
   // ----------------------------------------------------------------
   logic [4:0]  cnt_ff;
   logic [15:0] sh_ff;
   logic [1:0]  sel;
   logic        xfer;
   logic [11:0] data;

   assign sel  = {sh_ff[SEL_HI_POS], sh_ff[SEL_LO_POS]};
   assign xfer = (cnt_ff == WORD_LEN);
   assign data = sh_ff[11:0];

   // Own count, so a shared counting slip in the device still shows
   always_ff @(negedge sclk)
   begin
      if (rst || cs_n)
      begin
         cnt_ff <= CNT_ZERO;
      end
      else if (cnt_ff != WORD_LEN)
      begin
         cnt_ff <= cnt_ff + CNT_ONE;
         sh_ff  <= {sh_ff[14:0], din};
      end
   end

   default clocking cb @(posedge sclk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_word_moved: assert property (xfer |=>
      word_loaded && last_word == sh_ff)
      else $error("word not transferred after sixteen bits");
   chk_load_cause: assert property (word_loaded && !partial_loaded |->
      $past(xfer))
      else $error("full load without sixteen bits");
   chk_sel_b_buf: assert property (xfer && sel == SEL_B_AND_BUF |=>
      dac_b_code == data && hold_code == data && $stable(dac_a_code))
      else $error("select 00 did not load DAC B and buffer");
   chk_sel_buf: assert property (xfer && sel == SEL_BUF_ONLY |=>
      hold_code == data && $stable(dac_a_code) && $stable(dac_b_code))
      else $error("select 01 did not load buffer only");
   chk_sel_a_upd: assert property (xfer && sel == SEL_A_UPD_B |=>
      dac_a_code == data && dac_b_code == $past(hold_code))
      else $error("select 10 did not update both outputs");
   chk_reserved_keep: assert property (xfer && sel == SEL_RESERVED |=> reserved_seen &&
      $stable(dac_a_code) && $stable(dac_b_code) && $stable(hold_code))
      else $error("reserved select changed a latch");
   chk_speed_bit: assert property (xfer |=> speed_select == sh_ff[SPEED_POS])
      else $error("speed bit not taken from word");
   chk_power_bit: assert property (xfer |=> power_down_flag == sh_ff[PD_POS])
      else $error("power-down bit not taken from word");
   chk_reset_zero: assert property ($fell(rst) |-> dac_a_code == CODE_ZERO &&
      dac_b_code == CODE_ZERO && hold_code == CODE_ZERO && !speed_select && !power_down_flag)
      else $error("latches not zero after power-on reset");
endmodule
`default_nettype wire

// ==== tb/dual_dac_serial_loader_tb.sv ====
// Self-checking bench: controller and DAC loader joined by their serial link
`default_nettype none
module dual_dac_serial_loader_tb
   import dac_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic                 ref_clk;
   logic                 rst;
   logic                 dev_rst;
   logic [ADDR_W-1:0]    addr;
   logic [15:0]          wdata;
   logic                 wr;
   logic                 rd;
   logic [15:0]          rdata;
   logic [DATA_BITS-1:0] dac_a_code;
   logic [DATA_BITS-1:0] dac_b_code;
   logic [DATA_BITS-1:0] hold_code;
   logic                 speed_select;
   logic                 power_down_flag;
   logic                 word_loaded;
   logic                 partial_loaded;
   logic                 reserved_seen;
   logic [WORD_BITS-1:0] last_word;
   logic [15:0]          cap;
   logic [4:0]           nbits;
   logic [15:0]          loads;
   logic [15:0]          v;
   int                   num_errors;
   int                   checks_done;
   // Word sent and state expected after it; last word goes out in byte mode
   logic [15:0] words [5] = '{16'h4abc, 16'h1123, 16'h8fff, 16'hb555, 16'h0001};
   logic [11:0] ea [5]    = '{12'h000, 12'h000, 12'hfff, 12'hfff, 12'hfff};
   logic [11:0] eb [5]    = '{12'habc, 12'habc, 12'h123, 12'h123, 12'h001};
   logic [11:0] eh [5]    = '{12'habc, 12'h123, 12'h123, 12'h123, 12'h001};
   logic        es [5]    = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
   logic        ep [5]    = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

   dac_link_if link ();

   dac_loader_host i_dac_loader_host (.ref_clk(ref_clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));

   dac_loader_device i_dac_loader_device (.link(link), .rst(dev_rst),
      .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .hold_code(hold_code),
      .speed_select(speed_select), .power_down_flag(power_down_flag),
      .word_loaded(word_loaded), .partial_loaded(partial_loaded),
      .reserved_seen(reserved_seen), .last_word(last_word));

   dac_link_monitor i_dac_link_monitor (.cs_n(link.cs_n), .sclk(link.sclk), .din(link.din),
      .rst(dev_rst), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
      .hold_code(hold_code), .speed_select(speed_select),
      .power_down_flag(power_down_flag), .word_loaded(word_loaded),
      .partial_loaded(partial_loaded), .reserved_seen(reserved_seen),
      .last_word(last_word));

   always #50 ref_clk = ~ref_clk;

   // ----------------------------------------------------------------
   // Wire observers
   // ----------------------------------------------------------------
   always @(negedge link.sclk)
   begin
      if (link.cs_n === 1'b0)
      begin
         cap   = {cap[14:0], link.din};
         nbits = nbits + 5'h01;
      end
   end

   always @(posedge link.sclk)
   begin
      if (word_loaded === 1'b1)
         loads = loads + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // Bounded poll of the busy flag; a hang ends the run as a failure
   task automatic send_word(input logic [15:0] w);
      logic [15:0] s;
      int          n;
      cap   = 16'h0000;
      nbits = 5'h00;
      wr_reg(ADDR_WORD, w);
      for (n = 0; n < 100; n++)
      begin
         rd_reg(ADDR_STATUS, s);
         if (s[STAT_BUSY_POS] === 1'b0)
            break;
      end
      if (n == 100)
      begin
         num_errors++;
         stop_test();
      end
   endtask

   task automatic check_state(input logic [11:0] a, input logic [11:0] b,
                              input logic [11:0] h, input logic s, input logic p);
      chk("dac_a_code", {4'h0, a}, {4'h0, dac_a_code});
      chk("dac_b_code", {4'h0, b}, {4'h0, dac_b_code});
      chk("hold_code", {4'h0, h}, {4'h0, hold_code});
      chk("speed_select", {15'h0000, s}, {15'h0000, speed_select});
      chk("power_down_flag", {15'h0000, p}, {15'h0000, power_down_flag});
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk     = 1'b0;
      rst         = 1'b1;
      dev_rst     = 1'b1;
      addr        = ADDR_WORD;
      wdata       = 16'h0000;
      wr          = 1'b0;
      rd          = 1'b0;
      cap         = 16'h0000;
      nbits       = 5'h00;
      loads       = 16'h0000;
      num_errors  = 0;
      checks_done = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      // Device reset passes a three-stage chain on the link clock both ways
      repeat (12) @(posedge ref_clk);
      dev_rst <= 1'b0;
      repeat (10) @(posedge ref_clk);
      check_state(12'h000, 12'h000, 12'h000, 1'b0, 1'b0);
      for (int k = 0; k < 5; k++)
      begin
         if (k == 4)
            wr_reg(ADDR_CFG, 16'h0001);
         send_word(words[k]);
         chk("wire bits", words[k], cap);
         chk("bit count", 16'h0010, {11'h000, nbits});
         check_state(ea[k], eb[k], eh[k], es[k], ep[k]);
      end
      rd_reg(ADDR_STATUS, v);
      chk("words sent", 16'h0005, {8'h00, v[15:8]});
      rd_reg(2'h3, v);
      chk("unmapped read", 16'h0000, v);
      chk("loads", 16'h0005, loads);
      stop_test();
   end
endmodule
`default_nettype wire
